// ---- design/ppg_pkg.sv ----
// Purpose: Shared constants for the PWM pair generator.
// Assumes: Core clock ref_clk at 40 MHz.
// Notes: Widths are fixed; no register map, all controls are ports.
package ppg_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PPG_CNT_W = 15;
  localparam int PPG_DIV_W = 3;
  localparam int PPG_SEL_W = 2;
  localparam int PPG_CH_N = 2;

  // ---------------------------------------------------------------
  // Prescaler select codes
  // ---------------------------------------------------------------
  localparam logic [PPG_SEL_W-1:0] PPG_DIV1 = 2'h0;
  localparam logic [PPG_SEL_W-1:0] PPG_DIV2 = 2'h1;
  localparam logic [PPG_SEL_W-1:0] PPG_DIV4 = 2'h2;
  localparam logic [PPG_SEL_W-1:0] PPG_DIV8 = 2'h3;

  // Last prescaler count before a tick, one per divide ratio.
  localparam logic [PPG_DIV_W-1:0] PPG_DIV1_LAST = 3'h0;
  localparam logic [PPG_DIV_W-1:0] PPG_DIV2_LAST = 3'h1;
  localparam logic [PPG_DIV_W-1:0] PPG_DIV4_LAST = 3'h3;
  localparam logic [PPG_DIV_W-1:0] PPG_DIV8_LAST = 3'h7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [PPG_SEL_W-1:0] PPG_SEL_RST = PPG_DIV1;
  localparam logic [PPG_CNT_W-1:0] PPG_CNT_RST = 15'h0000;
  localparam logic [PPG_CNT_W-1:0] PPG_MOD_RST = 15'h0000;
  localparam logic [PPG_CNT_W-1:0] PPG_VAL_RST = 15'h0000;
  localparam logic [PPG_DIV_W-1:0] PPG_DIV_RST = 3'h0;
  localparam logic PPG_EDGE_RST = 1'b0;

  // Counter direction.
  typedef enum logic {
    PPG_UP = 1'b0,
    PPG_DOWN = 1'b1
  } ppg_dir_e;

endpackage : ppg_pkg

// ---- design/ppg_pwm_pair.sv ----
// Purpose: One PWM generator driving a channel pair with prescaler and 15-bit counter.
// Assumes: All control inputs come from logic on ref_clk, so none is synchronised.
// Notes: Settings other than compare_polarity_reg and double_switch_en are buffered and take effect on load_ok at a reload, or at once while stopped.
//
// Contract
// [R1] Counting clock is core clock divided by one, two, four or eight.
// [R2] New prescaler divisor waits in a buffer until load_ok and reload.
// [R3] A 15-bit counter counts up and down while producing the outputs.
// [R4] One alignment bit selects center or edge operation for both channels.
// [R5] Edge-aligned period equals the modulus in counting clock cycles.
// [R6] Center-aligned period equals twice the modulus in counting clock cycles.
// [R7] Center-aligned pulse width is twice the channel value.
// [R8] Edge-aligned pulse width equals the channel value.
// [R9] Counting down with value above count drives output high, or low if inverted.
// [R10] Counting up with count equal to value drives output low, or high if inverted.
// [R11] Complementary center mode offers double switching: AND of both compare results.
// [R12] Non-inverted value at or above modulus reduces double switching to one pulse.
// [R13] Center counts up to modulus and back; edge counts up and restarts. The code turns the center count at modulus minus one.
`timescale 1ns/1ps

module ppg_pwm_pair (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic run_en,
  input wire logic load_ok,
  input wire logic [ppg_pkg::PPG_SEL_W-1:0] prescale_sel,
  input wire logic edge_align,
  input wire logic [ppg_pkg::PPG_CNT_W-1:0] modulus,
  input wire logic [ppg_pkg::PPG_CNT_W-1:0] channel_value_reg0,
  input wire logic [ppg_pkg::PPG_CNT_W-1:0] channel_value_reg1,
  input wire logic [ppg_pkg::PPG_CH_N-1:0] compare_polarity_reg,
  input wire logic double_switch_en,
  output logic pwm_out0,
  output logic pwm_out1,
  output logic pwm_dbl_out,
  output logic reload_pulse,
  output logic [ppg_pkg::PPG_CNT_W-1:0] count_out,
  output logic count_down
);
  import ppg_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Terminal value of the prescaler counter for a select code.
  function automatic logic [PPG_DIV_W-1:0] div_last(input logic [PPG_SEL_W-1:0] sel);
    case (sel)
      PPG_DIV1: div_last = PPG_DIV1_LAST;
      PPG_DIV2: div_last = PPG_DIV2_LAST;
      PPG_DIV4: div_last = PPG_DIV4_LAST;
      PPG_DIV8: div_last = PPG_DIV8_LAST;
      default: div_last = PPG_DIV1_LAST;
    endcase
  endfunction : div_last

  // Next compare state for one channel, judged on the count just occupied.
  function automatic logic cmp_step(
    input logic cur,
    input logic edge_mode,
    input ppg_dir_e dir,
    input logic [PPG_CNT_W-1:0] cnt,
    input logic [PPG_CNT_W-1:0] val
  );
    cmp_step = cur;
    if (edge_mode && cnt == PPG_CNT_RST) begin
      cmp_step = (val != PPG_VAL_RST);
    end else if (dir == PPG_DOWN && val > cnt) begin
      cmp_step = 1'b1; // R9
    end else if (dir == PPG_UP && cnt == val) begin
      cmp_step = 1'b0; // R10
    end
  endfunction : cmp_step

  // ---------------------------------------------------------------
  // Active (buffered) settings
  // ---------------------------------------------------------------
  logic [PPG_SEL_W-1:0] sel_r;
  logic edge_r;
  logic [PPG_CNT_W-1:0] mod_r;
  logic [PPG_CNT_W-1:0] val0_r;
  logic [PPG_CNT_W-1:0] val1_r;
  logic [PPG_DIV_W-1:0] div_r;
  logic [PPG_CNT_W-1:0] cnt_r;
  logic [PPG_CNT_W-1:0] cnt_nxt;
  ppg_dir_e dir_r;
  ppg_dir_e dir_nxt;
  logic cmp0_r;
  logic cmp1_r;
  logic cmp0_nxt;
  logic cmp1_nxt;
  logic tick;
  logic at_top;
  logic reload;
  logic take;
  logic [PPG_CNT_W-1:0] mod_last;

  // A zero modulus behaves like one so the counter never runs away.
  assign mod_last = (mod_r == PPG_MOD_RST) ? PPG_CNT_RST : mod_r - 15'h0001;
  assign at_top = (cnt_r == mod_last);

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  assign tick = run_en && (div_r == div_last(sel_r)); // R1

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= PPG_DIV_RST;
    end else if (!run_en || tick) begin
      div_r <= PPG_DIV_RST; // R1
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Counter sequencing
  // ---------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    reload = 1'b0;
    if (edge_r) begin
      dir_nxt = PPG_UP;
      if (at_top) begin
        cnt_nxt = PPG_CNT_RST; // R5 R13
        reload = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 15'h0001;
      end
    end else if (dir_r == PPG_UP) begin
      if (at_top) begin
        dir_nxt = PPG_DOWN; // R6 R13
      end else begin
        cnt_nxt = cnt_r + 15'h0001;
      end
    end else begin
      if (cnt_r == PPG_CNT_RST) begin
        dir_nxt = PPG_UP; // R6 R13
        reload = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 15'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= PPG_CNT_RST;
      dir_r <= PPG_UP;
    end else if (!run_en) begin
      cnt_r <= PPG_CNT_RST;
      dir_r <= PPG_UP;
    end else if (tick) begin
      cnt_r <= cnt_nxt; // R3
      dir_r <= dir_nxt; // R3
    end
  end

  // ---------------------------------------------------------------
  // Buffer transfer
  // ---------------------------------------------------------------
  // While stopped, settings pass straight through on load_ok so the
  // first period starts with them; while running they wait for a reload.
  assign take = load_ok && (!run_en || (tick && reload)); // R2

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_r <= PPG_SEL_RST;
      edge_r <= PPG_EDGE_RST;
      mod_r <= PPG_MOD_RST;
      val0_r <= PPG_VAL_RST;
      val1_r <= PPG_VAL_RST;
    end else if (take) begin
      sel_r <= prescale_sel; // R2
      edge_r <= edge_align; // R4
      mod_r <= modulus;
      val0_r <= channel_value_reg0;
      val1_r <= channel_value_reg1;
    end
  end

  // ---------------------------------------------------------------
  // Compare channels
  // ---------------------------------------------------------------
  // Set on the down slope, or at count zero in edge mode, and clear on the
  // up slope gives twice the value in center mode, and the value itself in edge mode.
  assign cmp0_nxt = cmp_step(cmp0_r, edge_r, dir_r, cnt_r, val0_r); // R7 R8
  assign cmp1_nxt = cmp_step(cmp1_r, edge_r, dir_r, cnt_r, val1_r); // R7 R8

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmp0_r <= 1'b0;
      cmp1_r <= 1'b0;
    end else if (!run_en) begin
      cmp0_r <= 1'b0;
      cmp1_r <= 1'b0;
    end else if (tick) begin
      cmp0_r <= cmp0_nxt;
      cmp1_r <= cmp1_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pwm_out0 <= 1'b0;
      pwm_out1 <= 1'b0;
      pwm_dbl_out <= 1'b0;
    end else begin
      pwm_out0 <= cmp0_r ^ compare_polarity_reg[0]; // R9 R10
      pwm_out1 <= cmp1_r ^ compare_polarity_reg[1]; // R9 R10
      // A value at or above the modulus keeps its compare high, so the
      // AND follows the other channel alone: one pulse per period.
      pwm_dbl_out <= double_switch_en && !edge_r && cmp0_r && cmp1_r; // R11 R12
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reload_pulse <= 1'b0;
      count_out <= PPG_CNT_RST;
      count_down <= 1'b0;
    end else begin
      reload_pulse <= tick && reload;
      count_out <= cnt_r;
      count_down <= (dir_r == PPG_DOWN);
    end
  end

endmodule : ppg_pwm_pair

// ---- verif/ppg_pwm_pair_checker.sv ----
// Purpose: Port assertions for the PWM pair generator.
// Assumes: Modulus stays at 2 or more while the counter runs.
// Notes: Count or direction changes on every tick; at the turns only direction changes.
`timescale 1ns/1ps
module ppg_pwm_pair_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic run_en,
  input wire logic [ppg_pkg::PPG_CH_N-1:0] compare_polarity_reg,
  input wire logic double_switch_en,
  input wire logic pwm_out0,
  input wire logic pwm_out1,
  input wire logic pwm_dbl_out,
  input wire logic reload_pulse,
  input wire logic [ppg_pkg::PPG_CNT_W-1:0] count_out,
  input wire logic count_down
);
  import ppg_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [3:0] hold_r;
  // A stall longer than one divide-by-eight tick means the prescaler is wrong.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) hold_r <= 4'h0;
    else if (!run_en || $changed({count_down, count_out})) hold_r <= 4'h0;
    else if (hold_r != 4'hf) hold_r <= hold_r + 4'h1;
  end
  property p_tick_gap; run_en |-> hold_r < 4'ha; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick gap too long");
  property p_down_dec;
    count_down && $changed(count_out) |-> count_out == $past(count_out) - 15'h1;
  endproperty
  a_down_dec: assert property (p_down_dec) else $error("bad down step");
  property p_up_inc;
    !count_down && $changed(count_out) |->
      count_out == $past(count_out) + 15'h1 || count_out == 15'h0;
  endproperty
  a_up_inc: assert property (p_up_inc) else $error("bad up step");
  // The pulse comes with the count of the reload tick; the restart shows a clock later.
  property p_rel_zero; reload_pulse |=> count_out == 15'h0 && !count_down; endproperty
  a_rel_zero: assert property (p_rel_zero) else $error("reload off zero");
  property p_run_off; !run_en [*2] |=> count_out == 15'h0 && !count_down; endproperty
  a_run_off: assert property (p_run_off) else $error("count while off");
  property p_pol;
    !run_en [*3] |-> {pwm_out1, pwm_out0} == $past(compare_polarity_reg);
  endproperty
  a_pol: assert property (p_pol) else $error("idle polarity wrong");
  property p_dbl_and;
    pwm_dbl_out |-> (pwm_out0 ^ $past(compare_polarity_reg[0]))
      && (pwm_out1 ^ $past(compare_polarity_reg[1]));
  endproperty
  a_dbl_and: assert property (p_dbl_and) else $error("double not AND");
  property p_dbl_off; !$past(double_switch_en) |-> !pwm_dbl_out; endproperty
  a_dbl_off: assert property (p_dbl_off) else $error("double while off");
  c_rel: cover property (reload_pulse);
  c_dbl: cover property (pwm_dbl_out);
  c_down: cover property (count_down);
endmodule : ppg_pwm_pair_checker

// ---- verif/pwm_pair_generator_test.sv ----
// Purpose: Self-checking bench for the PWM pair generator.
// Assumes: Modulus 3 to 10, channel 0 value below modulus.
// Notes: Settings change while running, first without load, then with it.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module pwm_pair_generator_test;
  import ppg_pkg::*;
  logic ref_clk = 0, resetn = 0, run_en = 0, load_ok = 0, edge_align = 0, dsw = 0;
  logic meas = 0, o0, o1, dbl, rel, cdn;
  logic [PPG_SEL_W-1:0] sel = 0;
  logic [PPG_CNT_W-1:0] mod = 0, val0 = 0, val1 = 0, cnt;
  logic [1:0] pol = 0;
  logic [48:0] expq[$];
  logic [48:0] e_cur;
  logic [31:0] e_old;
  logic a_edge = 0, v1hi = 0;
  int bad_count = 0, checks = 0, cyc = 0, seed = 36, t0, t1, dcnt = 0, d0;
  always #12.5 ref_clk = ~ref_clk;
  ppg_pwm_pair dut (.ref_clk, .resetn, .run_en, .load_ok, .prescale_sel(sel), .edge_align,
    .modulus(mod), .channel_value_reg0(val0), .channel_value_reg1(val1),
    .compare_polarity_reg(pol), .double_switch_en(dsw), .pwm_out0(o0), .pwm_out1(o1),
    .pwm_dbl_out(dbl), .reload_pulse(rel), .count_out(cnt), .count_down(cdn));
  task automatic wrap_up;
    $display("mismatches=%0d comparisons=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Center mode doubles both period and width.
  function automatic logic [31:0] expv(int s, int e, int m, int v);
    int k = (e ? 1 : 2) << s;
    int p = k * m;
    int w = k * v;
    return {w[15:0], p[15:0]};
  endfunction : expv
  task automatic measure(input logic [31:0] e);
    repeat (40) @(negedge ref_clk);
    // Channel 1 holds the modulus, so its compare stays high once loaded.
    expq.push_back({v1hi ^ pol[1], ((dsw && !a_edge && v1hi) ? e[31:16] : 16'h0), e});
    meas = 1;
    wait (!meas);
    @(negedge ref_clk);
  endtask : measure
  always @(posedge ref_clk) begin
    // Blocking so the monitor, woken by an output edge, reads this edge's count.
    cyc++;
    if (dbl) dcnt++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial forever begin
    wait (meas);
    @(posedge o0);
    t0 = cyc;
    d0 = dcnt;
    @(negedge o0);
    t1 = cyc;
    @(posedge o0);
    e_cur = expq.pop_front();
    `CHK({16'(t1 - t0), 16'(cyc - t0)}, e_cur[31:0])
    `CHK(16'(dcnt - d0), e_cur[47:32])
    `CHK(o1, e_cur[48])
    meas = 0;
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    resetn = 1;
    mod = 15'h5;
    val0 = 15'h2;
    load_ok = 1;
    repeat (4) @(negedge ref_clk);
    load_ok = 0;
    run_en = 1;
    e_old = expv(0, 0, 5, 2);
    for (int i = 0; i < 8; i++) begin
      sel = i[1:0];
      edge_align = i[2];
      mod = 15'(3 + ($random(seed) & 7));
      val0 = 15'(1 + ({$random(seed)} % (mod - 15'h1)));
      val1 = mod;
      pol = {1'($random(seed)), 1'b0};
      dsw = 1'($random(seed));
      measure(e_old);
      load_ok = 1;
      repeat (340) @(negedge ref_clk);
      load_ok = 0;
      a_edge = edge_align;
      v1hi = 1;
      e_old = expv(sel, edge_align, mod, val0);
      measure(e_old);
    end
    // Stop with both channels inverted so the idle polarity is seen.
    run_en = 0;
    pol = 2'h3;
    repeat (8) @(negedge ref_clk);
    wrap_up();
  end
endmodule : pwm_pair_generator_test
bind ppg_pwm_pair ppg_pwm_pair_checker chk (.ref_clk, .resetn, .run_en, .compare_polarity_reg,
  .double_switch_en, .pwm_out0, .pwm_out1, .pwm_dbl_out, .reload_pulse, .count_out, .count_down);
